//--- hdl/usf_frame_ctrl.sv
// usf_frame_ctrl: serial transceiver control, framing and baud logic
// assumes a byte register port with read data one cycle after the strobe,
// and pins that are synchronous to core_clk
`timescale 1ns/1ps
`include "usf_consts.svh"
module usf_frame_ctrl (
	input  wire logic       core_clk,
	input  wire logic       arst_n,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	input  wire logic       global_irq_enable,
	output logic            tx_empty_irq,
	input  wire logic       rx_pin_in,
	output logic            rx_pin_own,
	output logic            tx_pin_out,
	output logic            tx_pin_oe,
	input  wire logic       sync_clk_in
);
	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		logic [7:0]          en;
		logic [7:0]          fmt;
		logic                u2x;
		logic [11:0]         baud;
		logic                txc;
		logic [8:0]          tx_buf;
		logic                tx_full;
		logic                tx_own;
		usf_pkg::usf_tx_st_t tx_st;
		logic [8:0]          tx_sh;
		logic                tx_par;
		logic [3:0]          tx_os;
		logic [3:0]          tx_bit;
		logic                tx_line;
		usf_pkg::usf_rx_st_t rx_st;
		logic [8:0]          rx_sh;
		logic                rx_par;
		logic                rx_perr;
		logic [3:0]          rx_os;
		logic [3:0]          rx_bit;
		logic [8:0]          rx_buf;
		logic                rx_full;
		logic                fe;
		logic                dor;
		logic                upe;
		logic                rx_own;
		logic [7:0]          rdata;
	} usf_fc_state_t;

	usf_fc_state_t r_reg;
	usf_fc_state_t r_next;

	logic       tick;
	logic       xck_rise;
	logic       xck_fall;
	logic       baud_reload;
	logic       sync_mode;
	logic [3:0] ovs_last;
	logic [3:0] nbits;
	logic       tx_step;
	logic       tx_chg;
	logic       rx_samp;
	logic       wr_hit;
	logic       rd_data;
	// prescaler load value: carries the byte being written on a low-byte write
	logic [11:0] baud_src;

	// ****************************************************************
	// helpers
	// ****************************************************************
	usf_baud_gen #(.W(12)) u_baud (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.baud_div (baud_src),
		.reload   (baud_reload),
		.tick     (tick)
	);

	usf_clk_edge u_xck (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.sig_in   (sync_clk_in),
		.rise     (xck_rise),
		.fall     (xck_fall)
	);

	// mode, divisor and size decode shared by both directions
	always_comb begin
		sync_mode = r_reg.fmt[`USF_FMT_MODE];
		// double speed only counts in asynchronous mode
		ovs_last = (r_reg.u2x && !sync_mode) ? `USF_OVS_LAST_DBL : `USF_OVS_LAST_NORM;
		nbits = usf_pkg::usf_char_bits({r_reg.en[`USF_EN_CSZ2], r_reg.fmt[2:1]});
		// polarity zero: change on rising, sample on falling
		tx_chg = r_reg.fmt[`USF_FMT_CPOL] ? xck_fall : xck_rise;
		tx_step = sync_mode ? tx_chg : (tick && (r_reg.tx_os == ovs_last));
		rx_samp = sync_mode ? (r_reg.fmt[`USF_FMT_CPOL] ? xck_rise : xck_fall)
			: (tick && (r_reg.rx_os == ovs_last));
		wr_hit = reg_wr;
		rd_data = reg_rd && (reg_addr == `USF_ADDR_DATA);
		baud_reload = reg_wr && (reg_addr == `USF_ADDR_BAUD_LO);
		// register copy lags the write by a cycle, so a reload takes the new byte directly
		baud_src = baud_reload ? {r_reg.baud[11:8], reg_wdata} : r_reg.baud;
	end

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		r_next = r_reg;

		// transmitter: oversample counter runs only inside a frame
		if (!sync_mode && tick && r_reg.tx_st != usf_pkg::TX_IDLE)
			r_next.tx_os = (r_reg.tx_os == ovs_last) ? 4'h0 : r_reg.tx_os + 4'h1;
		// a status write with the complete bit set clears the flag; a completion below still sets it
		if (wr_hit && reg_addr == `USF_ADDR_STATUS && reg_wdata[`USF_ST_TXC])
			r_next.txc = 1'b0;
		case (r_reg.tx_st)
			usf_pkg::TX_IDLE: begin
				r_next.tx_line = 1'b1;
				// a pending character still goes out after a disable was written
				if (r_reg.tx_full && r_reg.tx_own && (!sync_mode || tx_chg)) begin
					r_next.tx_st = usf_pkg::TX_START;
					r_next.tx_sh = r_reg.tx_buf;
					r_next.tx_par = usf_pkg::usf_parity(r_reg.tx_buf, nbits)
						^ r_reg.fmt[`USF_FMT_ODD];
					r_next.tx_full = 1'b0;
					r_next.tx_os = 4'h0;
					r_next.tx_line = 1'b0;
				end
			end
			usf_pkg::TX_START: begin
				if (tx_step) begin
					r_next.tx_st = usf_pkg::TX_DATA;
					r_next.tx_line = r_reg.tx_sh[0];
					r_next.tx_bit = 4'h0;
				end
			end
			usf_pkg::TX_DATA: begin
				if (tx_step) begin
					if (r_reg.tx_bit == nbits - 4'h1) begin
						// parity rides between last data bit and stop
						if (r_reg.fmt[`USF_FMT_PAR]) begin
							r_next.tx_st = usf_pkg::TX_PAR;
							r_next.tx_line = r_reg.tx_par;
						end else begin
							r_next.tx_st = usf_pkg::TX_STOP1;
							r_next.tx_line = 1'b1;
						end
					end else begin
						r_next.tx_bit = r_reg.tx_bit + 4'h1;
						r_next.tx_sh = {1'b0, r_reg.tx_sh[8:1]};
						r_next.tx_line = r_reg.tx_sh[1];
					end
				end
			end
			usf_pkg::TX_PAR: begin
				if (tx_step) begin
					r_next.tx_st = usf_pkg::TX_STOP1;
					r_next.tx_line = 1'b1;
				end
			end
			usf_pkg::TX_STOP1: begin
				if (tx_step) begin
					if (r_reg.fmt[`USF_FMT_STOP]) begin
						r_next.tx_st = usf_pkg::TX_STOP2;
					end else begin
						r_next.tx_st = usf_pkg::TX_IDLE;
						if (!r_reg.tx_full) r_next.txc = 1'b1;
					end
				end
			end
			usf_pkg::TX_STOP2: begin
				if (tx_step) begin
					r_next.tx_st = usf_pkg::TX_IDLE;
					if (!r_reg.tx_full) r_next.txc = 1'b1;
				end
			end
			default: r_next.tx_st = usf_pkg::TX_IDLE;
		endcase
		// pin stays ours until the last queued frame has left
		r_next.tx_own = r_reg.en[`USF_EN_TXEN] | (r_reg.tx_own
			& ((r_reg.tx_st != usf_pkg::TX_IDLE) | r_reg.tx_full));

		// receiver: sample clock and frame walk
		if (!sync_mode && tick && r_reg.rx_st != usf_pkg::RX_IDLE)
			r_next.rx_os = (r_reg.rx_os == ovs_last) ? 4'h0 : r_reg.rx_os + 4'h1;
		// reading the data byte frees the buffer and its flags
		if (rd_data) begin
			r_next.rx_full = 1'b0;
			r_next.fe = 1'b0;
			r_next.dor = 1'b0;
			r_next.upe = 1'b0;
		end
		case (r_reg.rx_st)
			usf_pkg::RX_IDLE: begin
				r_next.rx_sh = 9'h000;
				r_next.rx_par = r_reg.fmt[`USF_FMT_ODD];
				r_next.rx_bit = 4'h0;
				r_next.rx_os = 4'h0;
				if (sync_mode) begin
					if (rx_samp && !rx_pin_in) r_next.rx_st = usf_pkg::RX_DATA;
				end else if (!rx_pin_in) begin
					r_next.rx_st = usf_pkg::RX_START;
				end
			end
			usf_pkg::RX_START: begin
				// check the start bit at its middle, then step whole bits
				if (tick && r_reg.rx_os == (ovs_last >> 1)) begin
					r_next.rx_os = 4'h0;
					r_next.rx_st = rx_pin_in ? usf_pkg::RX_IDLE : usf_pkg::RX_DATA;
				end
			end
			usf_pkg::RX_DATA: begin
				if (rx_samp) begin
					r_next.rx_sh[r_reg.rx_bit] = rx_pin_in;
					r_next.rx_par = r_reg.rx_par ^ rx_pin_in;
					r_next.rx_bit = r_reg.rx_bit + 4'h1;
					if (r_reg.rx_bit == nbits - 4'h1)
						r_next.rx_st = r_reg.fmt[`USF_FMT_PAR] ? usf_pkg::RX_PAR
							: usf_pkg::RX_STOP;
				end
			end
			usf_pkg::RX_PAR: begin
				if (rx_samp) begin
					r_next.rx_perr = r_reg.rx_par ^ rx_pin_in;
					r_next.rx_st = usf_pkg::RX_STOP;
				end
			end
			usf_pkg::RX_STOP: begin
				// only the first stop bit is checked, whatever the stop select says
				if (rx_samp) begin
					r_next.rx_st = usf_pkg::RX_IDLE;
					if (r_reg.rx_full && !rd_data) begin
						r_next.dor = 1'b1;
					end else begin
						r_next.rx_buf = r_reg.rx_sh;
						r_next.rx_full = 1'b1;
						r_next.fe = !rx_pin_in;
						r_next.upe = r_reg.fmt[`USF_FMT_PAR] & r_reg.rx_perr;
					end
					r_next.rx_perr = 1'b0;
				end
			end
			default: r_next.rx_st = usf_pkg::RX_IDLE;
		endcase

		// register writes
		if (wr_hit) begin
			case (reg_addr)
				`USF_ADDR_STATUS: r_next.u2x = reg_wdata[`USF_ST_U2X];
				`USF_ADDR_ENCTL: r_next.en = reg_wdata & `USF_EN_WMASK;
				`USF_ADDR_FORMAT: r_next.fmt = reg_wdata & `USF_FMT_WMASK;
				`USF_ADDR_BAUD_LO: r_next.baud[7:0] = reg_wdata;
				`USF_ADDR_BAUD_HI: r_next.baud[11:8] = reg_wdata[3:0];
				`USF_ADDR_DATA: begin
					// a write while the buffer is full is dropped
					if (!r_reg.tx_full) begin
						r_next.tx_buf = {r_reg.en[`USF_EN_TXB8], reg_wdata};
						r_next.tx_full = 1'b1;
					end
				end
				default: r_next.rdata = r_next.rdata;
			endcase
		end

		// disabled receiver: drop buffer, flags and any frame in progress
		if (!r_reg.en[`USF_EN_RXEN]) begin
			r_next.rx_st = usf_pkg::RX_IDLE;
			r_next.rx_full = 1'b0;
			r_next.fe = 1'b0;
			r_next.dor = 1'b0;
			r_next.upe = 1'b0;
		end
		r_next.rx_own = r_reg.en[`USF_EN_RXEN];

		// read data, valid in the cycle after the strobe
		if (reg_rd) begin
			case (reg_addr)
				`USF_ADDR_STATUS: r_next.rdata = {r_reg.rx_full, r_reg.txc, !r_reg.tx_full,
					r_reg.fe, r_reg.dor, r_reg.upe, r_reg.u2x, 1'b0};
				`USF_ADDR_ENCTL: r_next.rdata = {r_reg.en[7:2], r_reg.rx_buf[8],
					r_reg.en[0]};
				`USF_ADDR_FORMAT: r_next.rdata = r_reg.fmt;
				`USF_ADDR_BAUD_LO: r_next.rdata = r_reg.baud[7:0];
				`USF_ADDR_BAUD_HI: r_next.rdata = {4'h0, r_reg.baud[11:8]};
				`USF_ADDR_DATA: r_next.rdata = r_reg.rx_buf[7:0];
				default: r_next.rdata = 8'h00;
			endcase
		end
	end

	// ****************************************************************
	// registers and outputs
	// ****************************************************************
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			r_reg <= '0;
			r_reg.fmt <= `USF_FMT_RESET;
			r_reg.baud <= `USF_BAUD_RESET;
			r_reg.tx_line <= 1'b1;
			r_reg.tx_st <= usf_pkg::TX_IDLE;
			r_reg.rx_st <= usf_pkg::RX_IDLE;
		end else begin
			r_reg <= r_next;
		end
	end

	// interrupt is plain gating, no latching of its own
	assign tx_empty_irq = r_reg.en[`USF_EN_UDRIE] & global_irq_enable & !r_reg.tx_full;
	assign reg_rdata = r_reg.rdata;
	assign rx_pin_own = r_reg.rx_own;
	assign tx_pin_oe = r_reg.tx_own;
	assign tx_pin_out = r_reg.tx_line;

	// ****************************************************************
	// checks
	// ****************************************************************
	a_irq_gating: assert property (@(posedge core_clk) disable iff (!arst_n)
		tx_empty_irq |-> (global_irq_enable && r_reg.en[5] && !r_reg.tx_full))
		else $error("empty interrupt without its three causes");
	a_rx_takes_pin: assert property (@(posedge core_clk) disable iff (!arst_n)
		(reg_wr && reg_addr == 8'hc1 && reg_wdata[4]) |=> ##1 rx_pin_own)
		else $error("receiver did not take the pin");
	a_rx_flush_all: assert property (@(posedge core_clk) disable iff (!arst_n)
		!r_reg.en[4] |=> (!r_reg.rx_full && !r_reg.fe && !r_reg.dor && !r_reg.upe))
		else $error("receive buffer not flushed");
	a_tx_release: assert property (@(posedge core_clk) disable iff (!arst_n)
		(!r_reg.en[3] && r_reg.tx_st == usf_pkg::TX_IDLE && !r_reg.tx_full
		&& !(reg_wr && reg_addr == 8'hc1)) |=> !tx_pin_oe)
		else $error("transmit pin not released");
	a_tx_drain_hold: assert property (@(posedge core_clk) disable iff (!arst_n)
		(tx_pin_oe && r_reg.tx_st != usf_pkg::TX_IDLE) |=> tx_pin_oe)
		else $error("pin released while a frame was in flight");
	a_par_on_line: assert property (@(posedge core_clk) disable iff (!arst_n)
		(r_reg.tx_st == usf_pkg::TX_PAR) |-> (tx_pin_out == r_reg.tx_par && r_reg.fmt[5]))
		else $error("parity bit wrong on the line");
	a_two_stops: assert property (@(posedge core_clk) disable iff (!arst_n)
		(r_reg.tx_st == usf_pkg::TX_STOP2) |-> (r_reg.fmt[3] && tx_pin_out))
		else $error("second stop bit without its select");
	a_rx_char_len: assert property (@(posedge core_clk) disable iff (!arst_n)
		(r_reg.en[4] && r_reg.rx_st == usf_pkg::RX_DATA && r_next.rx_st != usf_pkg::RX_DATA)
		|-> (r_reg.rx_bit == nbits - 4'h1))
		else $error("receive frame length wrong");
	a_sync_edges: assert property (@(posedge core_clk) disable iff (!arst_n)
		(r_reg.fmt[6] && !tx_chg && !reg_wr) |=> $stable(tx_pin_out))
		else $error("sync data changed off its edge");
	a_ovs_wrap: assert property (@(posedge core_clk) disable iff (!arst_n)
		(!sync_mode && tick && r_reg.tx_st != usf_pkg::TX_IDLE && r_reg.tx_os == ovs_last
		&& !reg_wr) |=> (r_reg.tx_os == 4'h0))
		else $error("oversample counter did not wrap");
endmodule // usf_frame_ctrl

//--- shared/usf_consts.svh
// usf_consts.svh: register offsets, field positions, reset values and counts
// assumes a byte-wide register port and a single core clock
// Overview of operation
// - empty-buffer interrupt only when enable, global enable and empty flag are all set
// - receiver owns the receive pin while its enable bit is one
// - disabling the receiver flushes its buffer and clears its error flags
// - transmitter drives the transmit pin while enabled, releases it when disabled
// - transmitter disable waits until shift register and buffer are empty
// - mode bit zero selects asynchronous, one selects synchronous operation
// - with parity enabled the transmitter appends data parity to every frame
// - parity field 00 off, 01 reserved, 10 even, 11 odd; receiver flags mismatch
// - stop select gives one or two transmit stop bits; receiver ignores it
// - size code 000-011 gives 5-8 bits, 111 nine bits, others reserved
// - sync polarity zero: send on rising, sample on falling; one reverses both
// - baud setting is twelve bits, high register upper four, low register lower eight
// - writing the low baud register reloads the prescaler at once
// - double speed in asynchronous mode divides by eight instead of sixteen
`ifndef USF_CONSTS_SVH
`define USF_CONSTS_SVH
// ****************************************************************
// register offsets
// ****************************************************************
`define USF_ADDR_STATUS  8'hc0
`define USF_ADDR_ENCTL   8'hc1
`define USF_ADDR_FORMAT  8'hc2
`define USF_ADDR_BAUD_LO 8'hc4
`define USF_ADDR_BAUD_HI 8'hc5
`define USF_ADDR_DATA    8'hc6
// ****************************************************************
// field positions, masks and reset values
// ****************************************************************
`define USF_ST_RXC   7
`define USF_ST_TXC   6
`define USF_ST_UDRE  5
`define USF_ST_FE    4
`define USF_ST_DOR   3
`define USF_ST_UPE   2
`define USF_ST_U2X   1
`define USF_EN_UDRIE 5
`define USF_EN_RXEN  4
`define USF_EN_TXEN  3
`define USF_EN_CSZ2  2
`define USF_EN_RXB8  1
`define USF_EN_TXB8  0
`define USF_FMT_MODE 6
`define USF_FMT_PAR  5
`define USF_FMT_ODD  4
`define USF_FMT_STOP 3
`define USF_FMT_CPOL 0
`define USF_EN_WMASK   8'hfd
`define USF_FMT_WMASK  8'h7f
`define USF_FMT_RESET  8'h06
`define USF_BAUD_RESET 12'h000
// last oversample index per bit: divide by 16 or by 8
`define USF_OVS_LAST_NORM 4'hf
`define USF_OVS_LAST_DBL  4'h7
`endif

//--- shared/usf_pkg.sv
// usf_pkg: state types and shared helper functions of the serial block
// assumes the constants header is included by each design file
package usf_pkg;
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP1, TX_STOP2} usf_tx_st_t;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} usf_rx_st_t;
	// data bits per frame from the three-bit size code; reserved codes act as 8
	function automatic logic [3:0] usf_char_bits(input logic [2:0] code);
		case (code)
			3'h0:    usf_char_bits = 4'h5;
			3'h1:    usf_char_bits = 4'h6;
			3'h2:    usf_char_bits = 4'h7;
			3'h7:    usf_char_bits = 4'h9;
			default: usf_char_bits = 4'h8;
		endcase
	endfunction
	// xor of the low nbits of a nine-bit character
	function automatic logic usf_parity(input logic [8:0] d, input logic [3:0] nbits);
		logic p;
		p = 1'b0;
		for (int i = 0; i < 9; i++) begin
			if (i < int'(nbits)) p = p ^ d[i];
		end
		usf_parity = p;
	endfunction
endpackage

//--- hdl/usf_baud_gen.sv
// usf_baud_gen: down-counting baud prescaler giving one tick per setting plus one clocks
// assumes the setting is steady except at a reload pulse
`timescale 1ns/1ps
`include "usf_consts.svh"
module usf_baud_gen #(
	parameter int W = 12
) (
	input  wire logic         core_clk,
	input  wire logic         arst_n,
	input  wire logic [W-1:0] baud_div,
	input  wire logic         reload,
	output logic              tick
);
	typedef struct packed {
		logic [W-1:0] cnt;
	} usf_bg_state_t;
	usf_bg_state_t r_reg;
	usf_bg_state_t r_next;

	// count down, tick and restart at zero; a reload restarts at once
	always_comb begin
		r_next = r_reg;
		tick = (r_reg.cnt == '0);
		if (reload) r_next.cnt = baud_div;
		else if (tick) r_next.cnt = baud_div;
		else r_next.cnt = r_reg.cnt - 1'b1;
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) r_reg <= '0;
		else r_reg <= r_next;
	end

	a_reload_takes: assert property (@(posedge core_clk) disable iff (!arst_n)
		reload |=> (r_reg.cnt == $past(baud_div)))
		else $error("prescaler did not reload");
endmodule // usf_baud_gen

//--- hdl/usf_clk_edge.sv
// usf_clk_edge: edge detector for the external synchronous clock
// assumes the clock input is already synchronous to core_clk
`timescale 1ns/1ps
module usf_clk_edge (
	input  wire logic core_clk,
	input  wire logic arst_n,
	input  wire logic sig_in,
	output logic      rise,
	output logic      fall
);
	typedef struct packed {
		logic prev;
	} usf_ce_state_t;
	usf_ce_state_t r_reg;
	usf_ce_state_t r_next;

	// compare the level with the last one seen
	always_comb begin
		r_next.prev = sig_in;
		rise = sig_in & ~r_reg.prev;
		fall = ~sig_in & r_reg.prev;
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) r_reg <= '0;
		else r_reg <= r_next;
	end
endmodule // usf_clk_edge

//--- tb/usf_remote_model.sv
// usf_remote_model: remote serial transceiver facing the frame control block
// assumes device frames whose first two data bits are one then zero
`timescale 1ns/1ps
module usf_remote_model (
	input  wire logic        core_clk,
	input  wire logic        tx_line,
	input  wire logic [15:0] bit_clks,
	input  wire logic [3:0]  nbits,
	input  wire logic        par_en,
	output logic             rx_line,
	output logic [8:0]       got_data,
	output logic             got_par,
	output logic [15:0]      run_len,
	output logic [15:0]      gap,
	output logic [7:0]       frames
);
	// ****************************************************************
	// frame decoder and frame sender
	// ****************************************************************
	int cyc = 0;
	int last_start = 0;
	int n;

	// free cycle count, used to time frame starts
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
	end

	// decode; the first bit may be short by prescaler phase, so bit zero's run is timed
	initial begin
		rx_line = 1'b1;
		frames = 8'h00;
		forever begin
			@(negedge tx_line);
			gap = 16'(cyc - last_start);
			last_start = cyc;
			@(posedge tx_line);
			n = 0;
			while (tx_line === 1'b1 && n < 2000) begin
				@(posedge core_clk);
				#1;
				n++;
			end
			run_len = 16'(n);
			got_data = 9'h001;
			repeat (bit_clks / 2) @(posedge core_clk);
			for (int i = 1; i < int'(nbits); i++) begin
				got_data[i] = tx_line;
				repeat (bit_clks) @(posedge core_clk);
			end
			got_par = par_en ? tx_line : 1'b0;
			frames = frames + 8'h01;
		end
	end

	// send one frame, lsb first, one stop bit; caller enters just after a clock edge
	task automatic send_frame(input logic [8:0] d, input logic pbit);
		rx_line <= 1'b0;
		repeat (bit_clks) @(posedge core_clk);
		for (int i = 0; i < int'(nbits); i++) begin
			rx_line <= d[i];
			repeat (bit_clks) @(posedge core_clk);
		end
		if (par_en) begin
			rx_line <= pbit;
			repeat (bit_clks) @(posedge core_clk);
		end
		rx_line <= 1'b1;
		repeat (bit_clks) @(posedge core_clk);
	endtask
endmodule // usf_remote_model

//--- tb/usf_frame_ctrl_test.sv
// usf_frame_ctrl_test: register port and serial line checks of the frame control block
// assumes the remote model on the serial lines and a 200 MHz core clock
`timescale 1ns/1ps
`include "usf_consts.svh"
module usf_frame_ctrl_test;
	// ****************************************************************
	// bench
	// ****************************************************************
	logic        core_clk = 1'b0;
	logic        arst_n = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        global_irq_enable = 1'b0;
	logic        sync_clk_in = 1'b0;
	logic [15:0] bit_clks = 16'h0020;
	logic [3:0]  nbits = 4'h9;
	logic        par_en = 1'b1;
	logic [7:0]  reg_rdata;
	logic        tx_empty_irq, rx_pin_in, rx_pin_own, tx_pin_out, tx_pin_oe, got_par;
	logic [8:0]  got_data;
	logic [15:0] run_len, gap;
	logic [7:0]  frames;
	int          failures = 0;
	int          checked = 0;
	int          k;

	usf_frame_ctrl usf_frame_ctrl_inst (.core_clk(core_clk), .arst_n(arst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .global_irq_enable(global_irq_enable),
		.tx_empty_irq(tx_empty_irq), .rx_pin_in(rx_pin_in), .rx_pin_own(rx_pin_own),
		.tx_pin_out(tx_pin_out), .tx_pin_oe(tx_pin_oe), .sync_clk_in(sync_clk_in));
	usf_remote_model usf_remote_model_inst (.core_clk(core_clk), .tx_line(tx_pin_out),
		.bit_clks(bit_clks), .nbits(nbits), .par_en(par_en), .rx_line(rx_pin_in),
		.got_data(got_data), .got_par(got_par), .run_len(run_len), .gap(gap), .frames(frames));

	// 5 ns period
	always #2.5 core_clk = ~core_clk;

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	// read data stand from the cycle after the strobe until the next read
	task automatic rd(input logic [7:0] a, input logic [7:0] mask, input logic [7:0] exp);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		check(16'(reg_rdata & mask), 16'(exp));
	endtask
	// bounded wait on the model's frame count
	task automatic wait_for(input logic [7:0] n);
		k = 0;
		while (frames !== n && k < 4000) begin
			@(posedge core_clk);
			k++;
		end
		if (k == 4000) begin
			failures++;
			conclude();
		end
	endtask
	task automatic conclude();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// main sequence: reset values, irq, transmit, receive, double speed, sync mode
	initial begin
		repeat (2) @(posedge core_clk);
		arst_n <= 1'b1;
		check(16'(tx_pin_oe), 16'h0);
		check(16'(rx_pin_own), 16'h0);
		rd(`USF_ADDR_FORMAT, 8'hff, `USF_FMT_RESET);
		rd(`USF_ADDR_BAUD_HI, 8'hff, 8'h00);
		rd(`USF_ADDR_ENCTL, 8'hff, 8'h00);
		rd(`USF_ADDR_STATUS, 8'hff, 8'h20);
		rd(8'hd0, 8'hff, 8'h00);
		wr(`USF_ADDR_BAUD_HI, 8'h0f);
		rd(`USF_ADDR_BAUD_HI, 8'hff, 8'h0f);
		wr(`USF_ADDR_BAUD_HI, 8'h00);
		wr(`USF_ADDR_BAUD_LO, 8'h01);
		rd(`USF_ADDR_BAUD_LO, 8'hff, 8'h01);
		wr(`USF_ADDR_FORMAT, 8'hff);
		rd(`USF_ADDR_FORMAT, 8'hff, 8'h7f);
		wr(`USF_ADDR_FORMAT, 8'h3e);
		wr(`USF_ADDR_ENCTL, 8'h3d);
		global_irq_enable <= 1'b1;
		@(posedge core_clk);
		#1;
		check(16'(tx_empty_irq), 16'h1);
		check(16'(rx_pin_own), 16'h1);
		check(16'(tx_pin_oe), 16'h1);
		@(posedge core_clk);
		global_irq_enable <= 1'b0;
		#1;
		check(16'(tx_empty_irq), 16'h0);
		@(posedge core_clk);
		global_irq_enable <= 1'b1;
		wr(`USF_ADDR_DATA, 8'ha5);
		wr(`USF_ADDR_DATA, 8'hc5);
		#1;
		check(16'(tx_empty_irq), 16'h0);
		wr(`USF_ADDR_ENCTL, 8'h34);
		wait_for(8'h01);
		check(16'(got_data), 16'h01a5);
		check(16'(got_par), 16'(~^9'h1a5));
		check(run_len, 16'd32);
		check(16'(tx_pin_oe), 16'h1);
		wait_for(8'h02);
		check(16'(got_data), 16'h01c5);
		check(16'(gap / 16'd32), 16'd13);
		k = 0;
		while (tx_pin_oe !== 1'b0 && k < 400) begin
			@(posedge core_clk);
			k++;
		end
		check(16'(tx_pin_oe), 16'h0);
		if (k == 400) begin
			failures++;
			conclude();
		end
		// receive with even then odd checking, parity bit always even
		for (int p = 0; p < 2; p++) begin
			wr(`USF_ADDR_FORMAT, {3'h1, p[0], 4'he});
			usf_remote_model_inst.send_frame(9'h0f3, ^9'h0f3);
			rd(`USF_ADDR_STATUS, 8'h84, {1'b1, 4'h0, p[0], 2'h0});
			rd(`USF_ADDR_ENCTL, 8'h02, 8'h00);
			rd(`USF_ADDR_DATA, 8'hff, 8'hf3);
		end
		@(posedge core_clk);
		usf_remote_model_inst.send_frame(9'h0f3, ^9'h0f3);
		wr(`USF_ADDR_ENCTL, 8'h04);
		rd(`USF_ADDR_STATUS, 8'h9c, 8'h00);
		check(16'(rx_pin_own), 16'h0);
		// double speed, eight bits, no parity
		wr(`USF_ADDR_STATUS, 8'h02);
		wr(`USF_ADDR_FORMAT, 8'h06);
		bit_clks <= 16'h0010;
		nbits <= 4'h8;
		par_en <= 1'b0;
		wr(`USF_ADDR_ENCTL, 8'h08);
		wr(`USF_ADDR_DATA, 8'hc5);
		wait_for(8'h03);
		check(16'(got_data), 16'h00c5);
		check(run_len, 16'd16);
		// let the stop bit finish before speed and mode change under it
		repeat (24) @(posedge core_clk);
		wr(`USF_ADDR_STATUS, 8'h00);
		// sync slave: idle clock at the polarity level, then the launching edge
		for (int c = 0; c < 2; c++) begin
			wr(`USF_ADDR_FORMAT, {7'h23, c[0]});
			sync_clk_in <= c[0];
			wr(`USF_ADDR_DATA, 8'h00);
			repeat (40) @(posedge core_clk);
			check(16'(tx_pin_out), 16'h1);
			sync_clk_in <= ~c[0];
			repeat (8) @(posedge core_clk);
			check(16'(tx_pin_out), 16'h0);
			repeat (24) begin
				repeat (8) @(posedge core_clk);
				sync_clk_in <= ~sync_clk_in;
			end
		end
		conclude();
	end
endmodule // usf_frame_ctrl_test
